// file: design/ssr_pkg.sv
// Package of offsets, bit positions and reset values for the status summary registers
`default_nettype none
package ssr_pkg;

    // Number of channels reporting an input error
    localparam int SSR_NUM_CH = 4;

    // Register indices; byte address is base plus four times the index
    localparam logic [11:0] SSR_UNIT_SUMMARY_IDX = 12'h000;
    localparam logic [11:0] SSR_MEM_FAULT_IDX = 12'h001;
    localparam logic [11:0] SSR_CHAN_STATUS_IDX = 12'h001;

    // Area bases and channel stride
    localparam logic [11:0] SSR_UNIT_AREA_BASE = 12'h000;
    localparam logic [11:0] SSR_CHAN_AREA_BASE = 12'h100;
    localparam logic [11:0] SSR_CHAN_STRIDE = 12'h020;

    // Event registers
    localparam logic [11:0] SSR_EVT_STATUS_ADDR = 12'h040;
    localparam logic [11:0] SSR_EVT_CLEAR_ADDR = 12'h044;
    localparam logic [11:0] SSR_EVT_ENABLE_ADDR = 12'h048;

    // Channel status word bits
    localparam int SSR_CH_INPUT_ERR_BIT = 6;
    localparam int SSR_CH_WRITE_OK_BIT = 25;

    // Unit summary word bits
    localparam int SSR_SUM_MEM_BIT = 0;
    localparam int SSR_SUM_CFG_BIT = 1;
    localparam int SSR_SUM_CHAN_BIT = 2;
    localparam int SSR_SUM_EXP_COMM_BIT = 4;
    localparam int SSR_SUM_IO_ERR_BIT = 10;
    localparam int SSR_SUM_LOW_IO_ERR_BIT = 11;
    localparam int SSR_SUM_IO_ALARM_BIT = 12;
    localparam int SSR_SUM_LOW_IO_ALARM_BIT = 13;
    localparam int SSR_SUM_IO_NOTIFY_BIT = 14;

    // Memory fault word bits
    localparam int SSR_MF_NVM_BIT = 4;
    localparam int SSR_MF_CAL_BIT = 5;
    localparam int SSR_MF_SETTING_BIT = 6;
    localparam int SSR_MF_CFG_REG_BIT = 8;
    localparam int SSR_MF_MODEL_BIT = 9;
    localparam int SSR_MF_MISMATCH_BIT = 12;

    // Reset values
    localparam logic [15:0] SSR_EVT_ENABLE_RST = 16'h0000;
    localparam logic [15:0] SSR_EVT_STATUS_RST = 16'h0000;
    localparam logic [31:0] SSR_PRDATA_RST = 32'h0000_0000;
    localparam logic [1:0] SSR_SYNC_RST = 2'h0;

    // Byte address of a word from its area base and index
    function automatic logic [11:0] ssr_word_addr(input logic [11:0] base,
                                                  input logic [11:0] idx);
        return 12'(base + {idx[9:0], 2'b00});
    endfunction : ssr_word_addr

endpackage : ssr_pkg
`default_nettype wire

// file: design/ssr_status_if.sv
// Interface carrying synchronised condition levels to the register bank
`timescale 1ns/1ps
`default_nettype none
interface ssr_status_if import ssr_pkg::*; ();
    logic [5:0] mem_fault;
    logic cfg_err;
    logic exp_comm_fail;
    logic io_err;
    logic low_io_err;
    logic io_alarm;
    logic low_io_alarm;
    logic io_notify;
    logic [SSR_NUM_CH-1:0] ch_input_err;

    modport src (output mem_fault, cfg_err, exp_comm_fail, io_err, low_io_err,
                 io_alarm, low_io_alarm, io_notify, ch_input_err);
    modport dst (input mem_fault, cfg_err, exp_comm_fail, io_err, low_io_err,
                 io_alarm, low_io_alarm, io_notify, ch_input_err);
endinterface : ssr_status_if
`default_nettype wire

// file: design/ssr_sync.sv
// Two-stage synchronisers for the asynchronous condition inputs
`timescale 1ns/1ps
`default_nettype none
module ssr_sync import ssr_pkg::*; #(
    parameter int WIDTH = 13 + SSR_NUM_CH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Raw levels from pins
    input wire logic [WIDTH-1:0] raw,
    // Synchronised levels
    ssr_status_if.src stat
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            held <= '0;
        end else begin
            meta <= raw;
            held <= meta;
        end
    end

    // Unpack into the named fields
    assign stat.mem_fault = held[5:0];
    assign stat.cfg_err = held[6];
    assign stat.exp_comm_fail = held[7];
    assign stat.io_err = held[8];
    assign stat.low_io_err = held[9];
    assign stat.io_alarm = held[10];
    assign stat.low_io_alarm = held[11];
    assign stat.io_notify = held[12];
    assign stat.ch_input_err = held[WIDTH-1:13];
endmodule : ssr_sync
`default_nettype wire

// file: design/ssr_top.sv
// Status summary register bank with APB slave and event interrupt
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ssr_top import ssr_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous condition inputs
    input wire logic [5:0] mem_fault_in,
    input wire logic cfg_err_in,
    input wire logic exp_comm_fail_in,
    input wire logic io_err_in,
    input wire logic low_io_err_in,
    input wire logic io_alarm_in,
    input wire logic low_io_alarm_in,
    input wire logic io_notify_in,
    input wire logic [SSR_NUM_CH-1:0] ch_input_err_in,
    // Interrupt
    output logic irq
);
    ssr_status_if stat ();

    logic [15:0] unit_summary_status;
    logic [15:0] memory_fault_status;
    logic [31:0] channel_status_word [SSR_NUM_CH];
    logic mem_any;
    logic chan_any;
    logic [15:0] summary_prev;
    logic [15:0] evt_status;
    logic [15:0] evt_enable;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // Condition pins are asynchronous; resynchronise them all
    ssr_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw({ch_input_err_in, io_notify_in, low_io_alarm_in, io_alarm_in,
              low_io_err_in, io_err_in, exp_comm_fail_in, cfg_err_in, mem_fault_in}),
        .stat(stat)
    );

    // Memory fault word; all other bits stay zero
    always_comb begin
        memory_fault_status = 16'h0000;
        memory_fault_status[SSR_MF_NVM_BIT] = stat.mem_fault[0];
        memory_fault_status[SSR_MF_CAL_BIT] = stat.mem_fault[1];
        memory_fault_status[SSR_MF_SETTING_BIT] = stat.mem_fault[2];
        memory_fault_status[SSR_MF_CFG_REG_BIT] = stat.mem_fault[3];
        memory_fault_status[SSR_MF_MODEL_BIT] = stat.mem_fault[4];
        memory_fault_status[SSR_MF_MISMATCH_BIT] = stat.mem_fault[5];
    end

    // Aggregates; mem_any is taken from the fault word itself so the two never disagree, chan_any from stat.ch_input_err
    assign mem_any = |memory_fault_status;
    assign chan_any = |stat.ch_input_err;

    // Unit summary word
    always_comb begin
        unit_summary_status = 16'h0000;
        unit_summary_status[SSR_SUM_MEM_BIT] = mem_any;
        unit_summary_status[SSR_SUM_CFG_BIT] = stat.cfg_err;
        unit_summary_status[SSR_SUM_CHAN_BIT] = chan_any;
        unit_summary_status[SSR_SUM_EXP_COMM_BIT] = stat.exp_comm_fail;
        unit_summary_status[SSR_SUM_IO_ERR_BIT] = stat.io_err;
        unit_summary_status[SSR_SUM_LOW_IO_ERR_BIT] = stat.low_io_err;
        unit_summary_status[SSR_SUM_IO_ALARM_BIT] = stat.io_alarm;
        unit_summary_status[SSR_SUM_LOW_IO_ALARM_BIT] = stat.low_io_alarm;
        unit_summary_status[SSR_SUM_IO_NOTIFY_BIT] = stat.io_notify;
    end

    // One channel status word per channel
    always_comb begin
        for (int c = 0; c < SSR_NUM_CH; c++) begin
            channel_status_word[c] = 32'h0000_0000;
            channel_status_word[c][SSR_CH_INPUT_ERR_BIT] = stat.ch_input_err[c];
            channel_status_word[c][SSR_CH_WRITE_OK_BIT] = 1'b1;
        end
    end

    // Bus phase decode
    wire setup_phase = psel & ~penable;
    wire access_wr = psel & penable & pwrite;

    // Address decode
    wire hit_summary = paddr == ssr_word_addr(SSR_UNIT_AREA_BASE, SSR_UNIT_SUMMARY_IDX);
    wire hit_memfault = paddr == ssr_word_addr(SSR_UNIT_AREA_BASE, SSR_MEM_FAULT_IDX);
    wire hit_evt_status = paddr == SSR_EVT_STATUS_ADDR;
    wire hit_evt_clear = paddr == SSR_EVT_CLEAR_ADDR;
    wire hit_evt_enable = paddr == SSR_EVT_ENABLE_ADDR;
    wire [11:0] chan_off = 12'(paddr - SSR_CHAN_AREA_BASE);
    wire chan_in_area = (paddr >= SSR_CHAN_AREA_BASE) &&
                        (chan_off < 12'(SSR_CHAN_STRIDE * SSR_NUM_CH));
    wire [1:0] chan_sel = 2'(chan_off / SSR_CHAN_STRIDE);
    wire [11:0] chan_word = 12'(chan_off % SSR_CHAN_STRIDE);
    wire hit_chan = chan_in_area &&
                    chan_word == ssr_word_addr(12'h000, SSR_CHAN_STATUS_IDX);
    wire hit_any = hit_summary | hit_memfault | hit_evt_status | hit_evt_clear |
                   hit_evt_enable | hit_chan;

    // Read data select; clear register is write-only and reads zero
    assign next_prdata =
        hit_summary ? {16'h0000, unit_summary_status} :
        hit_memfault ? {16'h0000, memory_fault_status} :
        hit_chan ? channel_status_word[chan_sel] :
        hit_evt_status ? {16'h0000, evt_status} :
        hit_evt_enable ? {16'h0000, evt_enable} :
        32'h0000_0000;
    assign next_pslverr = ~hit_any;

    // Zero wait states: data is captured in setup, so access always completes
    assign pready = 1'b1;

    // Answer registered in setup phase, stands through the access phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= SSR_PRDATA_RST;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? SSR_PRDATA_RST : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Only the enable and clear registers accept writes; status words ignore them
    wire wr_enable = access_wr & hit_evt_enable;
    wire wr_clear = access_wr & hit_evt_clear;
    wire [15:0] clear_mask = wr_clear ? pwdata[15:0] : 16'h0000;
    wire [15:0] rise = unit_summary_status & ~summary_prev;
    wire [15:0] next_evt_status = (evt_status & ~clear_mask) | rise;

    // Sticky events on rising summary bits; a new rise beats a clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_prev <= 16'h0000;
            evt_status <= SSR_EVT_STATUS_RST;
        end else begin
            summary_prev <= unit_summary_status;
            evt_status <= next_evt_status;
        end
    end

    // Interrupt enable register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_enable <= SSR_EVT_ENABLE_RST;
        end else if (wr_enable) begin
            evt_enable <= pwdata[15:0];
        end
    end

    // Level interrupt from flops only
    assign irq = |(evt_status & evt_enable);

endmodule : ssr_top
`default_nettype wire

// file: tb/ssr_top_asserts.sv
// Port checks for the status summary register bank
`timescale 1ns/1ps
`default_nettype none
module ssr_top_asserts import ssr_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Conditions
    input wire logic [5:0] mem_fault_in,
    input wire logic cfg_err_in,
    input wire logic exp_comm_fail_in,
    input wire logic io_err_in,
    input wire logic low_io_err_in,
    input wire logic io_alarm_in,
    input wire logic low_io_alarm_in,
    input wire logic io_notify_in,
    input wire logic [SSR_NUM_CH-1:0] ch_input_err_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Sync flops hold reset zeros at first; skip reads until they hold real samples
    logic [1:0] warm;
    logic [5:0] mf_p;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) warm <= 2'h0;
        else if (warm != 2'h3) warm <= warm + 2'h1;
    end
    // Fault inputs as the word sees them at the setup edge
    always_ff @(posedge core_clk) begin
        mf_p <= $past(mem_fault_in, 2);
    end
    // Setup-cycle read decodes
    wire logic rd_any = psel && !penable && !pwrite;
    wire logic rd_sum = rd_any && warm == 2'h3 && paddr == 12'h000;
    wire logic rd_mf = rd_any && warm == 2'h3 && paddr == 12'h004;
    wire logic rd_ch0 = rd_any && warm == 2'h3 && paddr == 12'h104;
    wire logic rd_ch = rd_any && paddr[11:7] == 5'h02 && paddr[4:0] == 5'h04;
    property p_ch_err; rd_ch0 |=> prdata[6] == $past(ch_input_err_in[0], 3); endproperty
    a_ch_err: assert property (p_ch_err) else $error("input error bit");
    property p_ch_ok; rd_ch |=> prdata[25] && prdata[31:26] == 6'h00; endproperty
    a_ch_ok: assert property (p_ch_ok) else $error("write permit bit");
    property p_mem; rd_sum |=> prdata[0] == |$past(mem_fault_in, 3); endproperty
    a_mem: assert property (p_mem) else $error("memory flag");
    property p_cfg; rd_sum |=> prdata[1] == $past(cfg_err_in, 3); endproperty
    a_cfg: assert property (p_cfg) else $error("config flag");
    property p_chan; rd_sum |=> prdata[2] == |$past(ch_input_err_in, 3); endproperty
    a_chan: assert property (p_chan) else $error("channel flag");
    property p_lvl;
        rd_sum |=> prdata[14:10] == {$past(io_notify_in, 3), $past(low_io_alarm_in, 3),
            $past(io_alarm_in, 3), $past(low_io_err_in, 3), $past(io_err_in, 3)}
            && prdata[4] == $past(exp_comm_fail_in, 3);
    endproperty
    a_lvl: assert property (p_lvl) else $error("summary levels");
    property p_mf;
        rd_mf |=> prdata == {19'h0, mf_p[5], 2'h0, mf_p[4:3], 1'b0, mf_p[2:0], 4'h0};
    endproperty
    a_mf: assert property (p_mf) else $error("fault word");
    property p_zero; rd_sum |=> prdata[31:15] == 17'h0 && prdata[9:5] == 5'h0 && !prdata[3]; endproperty
    a_zero: assert property (p_zero) else $error("unused bits");
    // Error response only for addresses outside the map, reads and writes alike
    property p_err;
        psel && !penable |=> pslverr == !($past(paddr) inside {12'h000, 12'h004, 12'h040,
            12'h044, 12'h048, 12'h104, 12'h124, 12'h144, 12'h164});
    endproperty
    a_err: assert property (p_err) else $error("error response");
endmodule : ssr_top_asserts
`default_nettype wire

// file: tb/ssr_host.sv
// Host model acting as APB master
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
    // Clock
    input wire logic core_clk,
    // APB master
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic pready
);
    // Idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // Released address and data lines show the inverse so a stale value never passes
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : ssr_host
`default_nettype wire

// file: tb/status_summary_registers_tb.sv
// Self-checking bench for the status summary register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, g, w); end end
module status_summary_registers_tb import ssr_pkg::*; ;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] pwdata, prdata;
    // Channels, notify, low alarm, alarm, low err, io err, exp, cfg, faults
    logic [16:0] c = 17'h00000;
    logic [32:0] expq[$];
    logic [32:0] e;
    int fail_count = 0;
    int compares = 0;
    int seed = 17;
    ssr_top u_dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .mem_fault_in(c[5:0]), .cfg_err_in(c[6]),
        .exp_comm_fail_in(c[7]), .io_err_in(c[8]), .low_io_err_in(c[9]),
        .io_alarm_in(c[10]), .low_io_alarm_in(c[11]), .io_notify_in(c[12]),
        .ch_input_err_in(c[16:13]), .irq);
    ssr_host u_host (.core_clk, .paddr, .psel, .penable, .pwrite, .pwdata, .pready);
    initial forever #4 core_clk = ~core_clk;
    function automatic logic [15:0] sumw(input logic [16:0] v);
        return {1'b0, v[12:8], 5'h00, v[7], 1'b0, |v[16:13], v[6], |v[5:0]};
    endfunction : sumw
    // A read notes its expected error flag and data first
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        expq.push_back(x);
        u_host.xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d);
    endtask : wr
    task automatic irq_is(input logic x);
        @(negedge core_clk);
        `CHK(irq, x)
    endtask : irq_is
    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Monitor: each completed read is compared with the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = (expq.size() > 0) ? expq.pop_front() : 33'h1_FFFF_FFFF;
            `CHK({pslverr, prdata}, e)
        end
    end
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(12'h048, 33'h0);
        rd(12'h0FC, 33'h1_0000_0000);
        // Walk one condition at a time, then random mixes, then all clear
        for (int i = 0; i < 26; i++) begin
            c <= (i < 17) ? 17'h00001 << i : (i < 25) ? 17'($random(seed)) : 17'h00000;
            repeat (4) @(posedge core_clk);
            rd(12'h000, {17'h0, sumw(c)});
            rd(12'h004, {20'h0, c[5], 2'h0, c[4:3], 1'b0, c[2:0], 4'h0});
            for (int n = 0; n < SSR_NUM_CH; n++)
                rd(12'h104 + 12'(n * 32), {8'h01, 18'h0, c[13 + n], 6'h0});
        end
        wr(12'h000, 32'hFFFF_FFFF);
        wr(12'h004, 32'hFFFF_FFFF);
        wr(12'h104, 32'hFFFF_FFFF);
        rd(12'h000, 33'h0);
        rd(12'h004, 33'h0);
        rd(12'h104, 33'h0_0200_0000);
        // Every summary bit rose during the walk; all stay latched while masked
        rd(12'h040, 33'h0_0000_7C17);
        rd(12'h044, 33'h0);
        irq_is(1'b0);
        // Event: clear all, enable config, raise and drop it, mask, clear
        wr(12'h044, 32'h0000_FFFF);
        rd(12'h040, 33'h0);
        wr(12'h048, 32'h0000_0002);
        rd(12'h048, 33'h0_0000_0002);
        c <= 17'h00040;
        repeat (6) @(posedge core_clk);
        c <= 17'h00000;
        irq_is(1'b1);
        rd(12'h040, 33'h0_0000_0002);
        wr(12'h048, 32'h0000_0000);
        irq_is(1'b0);
        wr(12'h048, 32'h0000_0002);
        irq_is(1'b1);
        wr(12'h044, 32'h0000_0002);
        irq_is(1'b0);
        rd(12'h040, 33'h0);
        @(negedge core_clk);
        `CHK(expq.size(), 0)
        conclude();
    end
endmodule : status_summary_registers_tb
bind ssr_top ssr_top_asserts u_chk (.*);
`default_nettype wire
